// file: sio_device.sv
`include "sio_params.svh"
module sio_device
   import sio_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   sio_bus_if.device        bus,
   input  wire logic [10:0] board_strap_fitted_i,
   input  wire logic        access_privilege_strap_i,
   input  wire logic [15:0] pair_strap_fitted_i,
   output sio_src_t         input_source_o,
   output sio_gain_t        programmable_gain_amplifier_o,
   output logic     [15:0]  pair_differential_o,
   output logic     [15:0]  control_status_word_o,
   output logic     [15:0]  gain_word_o
);
   // ************************************************************
   // state
   // ************************************************************
   sio_dev_st_t st_r;
   sio_dev_st_t st_nxt;
   logic [10:0] board_addr;
   logic        am_ok;
   logic        hit;
   logic [3:0]  sel;

   // fitted strap pulls the bit low
   assign board_addr = ~st_r.strap_s2;

   // decode on synchronised copies only; the first stage feeds nothing else
   always_comb begin
      sel   = st_r.addr_s2[`SIO_SEL_MSB:`SIO_SEL_LSB];
      // strap fitted: nonprivileged, absent: supervisory
      am_ok = (st_r.am_s2 == (st_r.priv_s2 ?
               `SIO_AM_NONPRIV : `SIO_AM_SUPER));
      hit   = !st_r.as_s2 && !st_r.ds_s2 && am_ok
              && (st_r.addr_s2[`SIO_BOARD_MSB:`SIO_BOARD_LSB]
                  == board_addr);
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_nxt         = st_r;
      st_nxt.addr_s1 = bus.addr;
      st_nxt.addr_s2 = st_r.addr_s1;
      st_nxt.am_s1   = bus.am;
      st_nxt.am_s2   = st_r.am_s1;
      st_nxt.as_s1   = bus.as_n;
      st_nxt.as_s2   = st_r.as_s1;
      st_nxt.ds_s1   = bus.ds_n;
      st_nxt.ds_s2   = st_r.ds_s1;
      st_nxt.wr_s1   = bus.write_n;
      st_nxt.wr_s2   = st_r.wr_s1;
      st_nxt.wd_s1   = bus.data_m;
      st_nxt.wd_s2   = st_r.wd_s1;
      // straps are pins: two stages before any decode reads them
      st_nxt.strap_s1 = board_strap_fitted_i;
      st_nxt.strap_s2 = st_r.strap_s1;
      st_nxt.priv_s1  = access_privilege_strap_i;
      st_nxt.priv_s2  = st_r.priv_s1;
      st_nxt.pair_s1  = pair_strap_fitted_i;
      st_nxt.pair_s2  = st_r.pair_s1;
      // one access per strobe: act only on the first matching cycle
      if (hit && !st_r.ack) begin
         st_nxt.ack   = 1'b1;
         st_nxt.rdata = 16'h0000;
         if (!st_r.wr_s2) begin
            case (sel)
               `SIO_OFS_CTRL >> 1: st_nxt.ctrl = st_r.wd_s2;
               `SIO_OFS_GAIN >> 1: st_nxt.gain = st_r.wd_s2;
               default: ;
            endcase
         end else begin
            case (sel)
               `SIO_OFS_ID >> 1:
                  st_nxt.rdata = {`SIO_ID_CODE, 8'h00};
               `SIO_OFS_CTRL >> 1: st_nxt.rdata = st_r.ctrl;
               `SIO_OFS_GAIN >> 1: st_nxt.rdata = st_r.gain;
               default: st_nxt.rdata = 16'h0000;
            endcase
         end
      end else if (st_r.ds_s2 || st_r.as_s2) begin
         st_nxt.ack = 1'b0; // strobe gone, release acknowledge
      end
   end

   // ************************************************************
   // register
   // ************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_r       <= '0;
         st_r.ctrl  <= `SIO_CTRL_RST;
         st_r.gain  <= `SIO_GAIN_RST;
         st_r.as_s1 <= 1'b1;
         st_r.as_s2 <= 1'b1;
         st_r.ds_s1 <= 1'b1;
         st_r.ds_s2 <= 1'b1;
         st_r.wr_s1 <= 1'b1;
         st_r.wr_s2 <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // data and acknowledge only driven while this board holds the cycle
   assign bus.data_s      = st_r.rdata;
   assign bus.data_s_oe_n = !(st_r.ack && st_r.wr_s2);
   assign bus.dtack_n     = !st_r.ack;
   assign bus.dtack_oe_n  = !st_r.ack;

   // source and gain decode; unlisted codes select SIO_SRC_OTHER and SIO_GAIN_10
   always_comb begin
      case (st_r.ctrl)
         `SIO_CTRL_SELFZERO: input_source_o = SIO_SRC_SELF_ZERO;
         `SIO_CTRL_DIFF00:   input_source_o = SIO_SRC_DIFF_PAIR;
         `SIO_CTRL_SE00:     input_source_o = SIO_SRC_SINGLE;
         default:            input_source_o = SIO_SRC_OTHER;
      endcase
      case (st_r.gain)
         `SIO_GAIN_X1:   programmable_gain_amplifier_o = SIO_GAIN_1;
         `SIO_GAIN_X100: programmable_gain_amplifier_o = SIO_GAIN_100;
         `SIO_GAIN_X500: programmable_gain_amplifier_o = SIO_GAIN_500;
         default:        programmable_gain_amplifier_o = SIO_GAIN_10;
      endcase
   end

   // absent strap leaves the pair differential
   assign pair_differential_o   = ~st_r.pair_s2;
   assign control_status_word_o = st_r.ctrl;
   assign gain_word_o           = st_r.gain;
endmodule

// file: sio_params.svh
`ifndef SIO_PARAMS_SVH
`define SIO_PARAMS_SVH
// ************************************************************
// board offsets (byte address within the 32-byte window)
// ************************************************************
`define SIO_OFS_ID        4'h0
`define SIO_OFS_CTRL      4'h2
`define SIO_OFS_GAIN      4'hE
// ************************************************************
// field layout and values
// ************************************************************
`define SIO_BOARD_LSB     5
`define SIO_BOARD_MSB     15
`define SIO_SEL_LSB       1
`define SIO_SEL_MSB       4
`define SIO_AM_PRIV_BIT   2
// arbitrary identification value, left-justified in the data word
`define SIO_ID_CODE       8'h5A
`define SIO_CTRL_SELFZERO 16'h0000
`define SIO_CTRL_DIFF00   16'h0100
`define SIO_CTRL_SE00     16'h0200
`define SIO_GAIN_X1       16'h0000
`define SIO_GAIN_X100     16'h0002
`define SIO_GAIN_X500     16'h0003
`define SIO_CTRL_RST      16'h0000
`define SIO_GAIN_RST      16'h0000
// short supervisory / nonprivileged data access modifiers
`define SIO_AM_SUPER      6'h2D
`define SIO_AM_NONPRIV    6'h29
`endif

// file: sio_pkg.sv
`include "sio_params.svh"
package sio_pkg;
   // converter input source decoded from control word
   typedef enum logic [1:0] {
      SIO_SRC_SELF_ZERO,
      SIO_SRC_DIFF_PAIR,
      SIO_SRC_SINGLE,
      SIO_SRC_OTHER
   } sio_src_t;
   // amplifier gain decoded from gain register
   typedef enum logic [1:0] {
      SIO_GAIN_1,
      SIO_GAIN_10,
      SIO_GAIN_100,
      SIO_GAIN_500
   } sio_gain_t;
   // master sequencer states
   typedef enum logic [1:0] {
      SIO_M_IDLE,
      SIO_M_STROBE,
      SIO_M_RELEASE
   } sio_mst_t;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] gain;
      logic [15:0] rdata;
      logic        ack;
      logic [15:0] addr_s1;
      logic [15:0] addr_s2;
      logic [5:0]  am_s1;
      logic [5:0]  am_s2;
      logic        as_s1;
      logic        as_s2;
      logic        ds_s1;
      logic        ds_s2;
      logic        wr_s1;
      logic        wr_s2;
      logic [15:0] wd_s1;
      logic [15:0] wd_s2;
      logic [10:0] strap_s1;
      logic [10:0] strap_s2;
      logic        priv_s1;
      logic        priv_s2;
      logic [15:0] pair_s1;
      logic [15:0] pair_s2;
   } sio_dev_st_t;
   typedef struct packed {
      sio_mst_t    state;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [5:0]  am;
      logic        wr;
      logic [15:0] rdata;
      logic        done;
      logic        ack_s1;
      logic        ack_s2;
      logic [15:0] d_s1;
      logic [15:0] d_s2;
      logic        miss_s1;
      logic        miss_s2;
   } sio_mst_st_t;
endpackage

// file: sio_bus_if.sv
interface sio_bus_if;
   // simplified short I/O bus: one slave, no arbitration
   logic [15:0] addr;
   logic [5:0]  am;
   logic        as_n;
   logic        ds_n;
   logic        write_n;
   logic [15:0] data_m;
   logic [15:0] data_s;
   logic        data_s_oe_n;
   logic        dtack_n;
   logic        dtack_oe_n;
   modport device (
      input  addr, am, as_n, ds_n, write_n, data_m,
      output data_s, data_s_oe_n, dtack_n, dtack_oe_n
   );
   modport master (
      output addr, am, as_n, ds_n, write_n, data_m,
      input  data_s, data_s_oe_n, dtack_n, dtack_oe_n
   );
endinterface

// file: sio_master.sv
`include "sio_params.svh"
module sio_master
   import sio_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   sio_bus_if.master        bus,
   input  wire logic        req_i,
   input  wire logic        req_write_i,
   input  wire logic        req_nonpriv_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [15:0] req_wdata_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [15:0]      rdata_o
);
   // ************************************************************
   // state
   // ************************************************************
   sio_mst_st_t st_r;
   sio_mst_st_t st_nxt;

   // sequence: present address, strobe, wait acknowledge, release
   always_comb begin
      st_nxt         = st_r;
      st_nxt.done    = 1'b0;
      st_nxt.ack_s1  = !bus.dtack_oe_n && !bus.dtack_n;
      st_nxt.ack_s2  = st_r.ack_s1;
      st_nxt.d_s1    = bus.data_s;
      st_nxt.d_s2    = st_r.d_s1;
      st_nxt.miss_s1 = 1'b0;
      st_nxt.miss_s2 = st_r.miss_s1;
      case (st_r.state)
         SIO_M_IDLE: begin
            if (req_i) begin
               st_nxt.addr  = req_addr_i;
               st_nxt.wdata = req_wdata_i;
               st_nxt.wr    = req_write_i;
               st_nxt.am    = req_nonpriv_i ? `SIO_AM_NONPRIV
                                            : `SIO_AM_SUPER;
               st_nxt.state = SIO_M_STROBE;
            end
         end
         SIO_M_STROBE: begin
            // no timeout: an unanswered cycle waits for reset
            if (st_r.ack_s2) begin
               if (!st_r.wr)
                  st_nxt.rdata = st_r.d_s2;
               st_nxt.state = SIO_M_RELEASE;
            end
         end
         SIO_M_RELEASE: begin
            if (!st_r.ack_s2) begin
               st_nxt.done  = 1'b1;
               st_nxt.state = SIO_M_IDLE;
            end
         end
         default: st_nxt.state = SIO_M_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign bus.addr    = st_r.addr;
   assign bus.am      = st_r.am;
   assign bus.as_n    = (st_r.state != SIO_M_STROBE);
   assign bus.ds_n    = (st_r.state != SIO_M_STROBE);
   assign bus.write_n = !st_r.wr;
   assign bus.data_m  = st_r.wdata;
   assign busy_o      = (st_r.state != SIO_M_IDLE);
   assign done_o      = st_r.done;
   assign rdata_o     = st_r.rdata;
endmodule

// file: sio_bus_checker.sv
`include "sio_params.svh"
// *****
// handshake checks on the joining bus
// *****
module sio_bus_checker (
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [15:0] addr,
   input wire logic [5:0]  am,
   input wire logic        as_n,
   input wire logic        ds_n,
   input wire logic        write_n,
   input wire logic [15:0] data_s,
   input wire logic        data_s_oe_n,
   input wire logic        dtack_n,
   input wire logic        dtack_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // strobes cross two synchronisers before any answer
   AST_ACK_CAUSE: assert property (
      $fell(dtack_n) |-> $past(!as_n && !ds_n, 2))
      else $error("acknowledge without strobes");
   AST_ACK_AM: assert property (
      $fell(dtack_n) |-> am == `SIO_AM_SUPER || am == `SIO_AM_NONPRIV)
      else $error("acknowledge on foreign modifier");
   AST_ACK_HOLD: assert property (
      !dtack_n && !ds_n |=> !dtack_n)
      else $error("acknowledge dropped early");
   // release is bounded so a stuck acknowledge shows up
   AST_ACK_DROP: assert property (
      $rose(ds_n) |-> ##[1:4] dtack_n)
      else $error("acknowledge not released");
   AST_OE_TIE: assert property (
      dtack_oe_n == dtack_n)
      else $error("acknowledge enable mismatch");
   AST_RD_DATA: assert property (
      $fell(data_s_oe_n) |-> write_n && !dtack_n)
      else $error("read data without acknowledge");
   AST_WR_QUIET: assert property (
      !write_n && !ds_n |-> data_s_oe_n)
      else $error("data driven in write cycle");
   AST_ID_WORD: assert property (
      !data_s_oe_n && addr[4:1] == 4'h0 |-> data_s == {`SIO_ID_CODE, 8'h00})
      else $error("wrong identification word");
   AST_UNMAPPED: assert property (
      !data_s_oe_n && addr[4:1] == 4'h4 |-> data_s == 16'h0000)
      else $error("unmapped read not zero");
   // main traffic seen
   cover property ($fell(dtack_n) && !write_n);
   cover property ($fell(data_s_oe_n));
   cover property (!data_s_oe_n && addr[4:1] == 4'h0);
endmodule

// file: tb_top.sv
`include "sio_params.svh"
module tb_top import sio_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] BASE = 16'h8F80;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        req_i = 1'b0;
   logic        req_write_i = 1'b0;
   logic        req_nonpriv_i = 1'b0;
   logic [15:0] req_addr_i = 16'h0000;
   logic [15:0] req_wdata_i = 16'h0000;
   logic        priv_strap = 1'b0;
   logic [15:0] pair_fit = 16'hA5C3;
   logic        busy_o, done_o;
   logic [15:0] rdata_o, pair_diff, ctrl_word, gain_word;
   sio_src_t    src;
   sio_gain_t   gain;
   int          fails = 0;
   int          compares = 0;
   // *****
   // ends of the bus
   // *****
   always #2.5 sys_clk_i = ~sys_clk_i;
   sio_bus_if sio_bus_if_i ();
   sio_device sio_device_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .bus(sio_bus_if_i), .board_strap_fitted_i(11'h383),
      .access_privilege_strap_i(priv_strap), .pair_strap_fitted_i(pair_fit),
      .input_source_o(src), .programmable_gain_amplifier_o(gain),
      .pair_differential_o(pair_diff), .control_status_word_o(ctrl_word),
      .gain_word_o(gain_word));
   sio_master sio_master_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .bus(sio_bus_if_i), .req_i(req_i), .req_write_i(req_write_i),
      .req_nonpriv_i(req_nonpriv_i), .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o),
      .rdata_o(rdata_o));
   sio_bus_checker sio_bus_checker_i (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .addr(sio_bus_if_i.addr), .am(sio_bus_if_i.am),
      .as_n(sio_bus_if_i.as_n), .ds_n(sio_bus_if_i.ds_n),
      .write_n(sio_bus_if_i.write_n), .data_s(sio_bus_if_i.data_s),
      .data_s_oe_n(sio_bus_if_i.data_s_oe_n),
      .dtack_n(sio_bus_if_i.dtack_n), .dtack_oe_n(sio_bus_if_i.dtack_oe_n));
   // *****
   // shared tasks
   // *****
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // request held until the master is busy, so it is taken only once
   task automatic bus_op(input logic wr, input logic [15:0] a,
                         input logic [15:0] d);
      int n;
      @(negedge sys_clk_i);
      req_i = 1'b1;
      req_write_i = wr;
      req_addr_i = a;
      req_wdata_i = d;
      for (n = 0; n < 20 && busy_o !== 1'b1; n++) @(negedge sys_clk_i);
      req_i = 1'b0;
      for (n = 0; n < 40 && done_o !== 1'b1; n++) @(negedge sys_clk_i);
      if (n >= 40) begin
         fails++;
         complete_run();
      end
   endtask
   // *****
   // scenarios
   // *****
   task automatic t_regs();
      logic [15:0] cw [3] = '{16'h0000, 16'h0100, 16'h0200};
      logic [15:0] gw [3] = '{16'h0003, 16'h0002, 16'h0000};
      sio_src_t    cs [3] = '{SIO_SRC_SELF_ZERO, SIO_SRC_DIFF_PAIR,
                              SIO_SRC_SINGLE};
      sio_gain_t   gs [3] = '{SIO_GAIN_500, SIO_GAIN_100, SIO_GAIN_1};
      for (int i = 0; i < 3; i++) begin
         bus_op(1'b1, BASE | 16'h0002, cw[i]);
         bus_op(1'b1, BASE | 16'h000E, gw[i]);
         chk16(16'(src), 16'(cs[i]), "source");
         chk16(16'(gain), 16'(gs[i]), "gain");
         bus_op(1'b0, BASE | 16'h0002, 16'h0000);
         chk16(rdata_o, cw[i], "control readback");
         bus_op(1'b0, BASE | 16'h000E, 16'h0000);
         chk16(rdata_o, gw[i], "gain readback");
      end
      bus_op(1'b1, BASE | 16'h000E, 16'h0001);
      chk16(16'(gain), 16'(SIO_GAIN_10), "gain other");
      bus_op(1'b1, BASE | 16'h0002, 16'h0300);
      chk16(16'(src), 16'(SIO_SRC_OTHER), "source other");
   endtask
   task automatic t_id();
      chk16(ctrl_word | gain_word, 16'h0000, "reset words");
      bus_op(1'b0, BASE, 16'h0000);
      chk16(rdata_o, {`SIO_ID_CODE, 8'h00}, "id word");
      bus_op(1'b0, BASE | 16'h0008, 16'hFFFF);
      chk16(rdata_o, 16'h0000, "unmapped read");
   endtask
   // a refused cycle hangs the master, so reset is the only way out
   task automatic t_refuse(input logic [15:0] a, input logic np);
      req_nonpriv_i = priv_strap;
      bus_op(1'b1, BASE | 16'h0002, 16'h0100);
      req_nonpriv_i = np;
      req_i = 1'b1;
      req_addr_i = a;
      req_wdata_i = 16'h0200;
      repeat (30) @(negedge sys_clk_i);
      chk16({15'h0, sio_bus_if_i.dtack_oe_n}, 16'h0001, "no ack");
      chk16(ctrl_word, 16'h0100, "refused write");
      req_i = 1'b0;
      sys_rst_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      chk16(ctrl_word, 16'h0000, "reset control");
      repeat (2) @(negedge sys_clk_i);
   endtask
   initial begin
      repeat (12) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      chk16(pair_diff, 16'h5A3C, "pair mode");
      t_id();
      t_regs();
      t_refuse(BASE ^ 16'h8002, 1'b0);
      t_refuse(BASE ^ 16'h0022, 1'b0);
      t_refuse(BASE | 16'h0002, 1'b1);
      priv_strap = 1'b1;
      pair_fit = 16'h0FF0;
      t_refuse(BASE | 16'h0002, 1'b0);
      chk16(pair_diff, 16'hF00F, "pair mode");
      complete_run();
   end
endmodule
